// [rtl/dmso_map.vh]
// opcode, operand, control-bit and reset-value constants of the executor
`ifndef DMSO_MAP_VH
`define DMSO_MAP_VH

// ****************************************
// instruction codes
// ****************************************
`define DMSO_OP_NOP    4'h0
`define DMSO_OP_MULT   4'h1
`define DMSO_OP_NOT    4'h2
`define DMSO_OP_OR     4'h3
`define DMSO_OP_PUSH   4'h4
`define DMSO_OP_POP    4'h5
`define DMSO_OP_RST    4'h6
`define DMSO_OP_BCLR   4'h7
`define DMSO_OP_BITS   4'h8
`define DMSO_OP_LOAD   4'h9

// ****************************************
// accumulator operand selects
// ****************************************
`define DMSO_SEL_A     2'h0
`define DMSO_SEL_B     2'h1
`define DMSO_SEL_R     2'h2

// ****************************************
// control bit addresses
// ****************************************
`define DMSO_BIT_CTL0  7'h36
`define DMSO_BIT_CTL1  7'h37
`define DMSO_BIT_PAGE  7'h38

// ****************************************
// sequence length and reset values
// ****************************************
`define DMSO_RST_STEPS 3'h5
`define DMSO_ACC_RST   32'h0000_0000
`define DMSO_PTR_RST   7'h00

`endif

// [rtl/dmso_stack_mem.v]
// small ram holding the older entries of the ram address stack
`timescale 1ns/10ps
module dmso_stack_mem #(
  parameter AW = 3,
  parameter DW = 7
) (
  input  wire          clk_sys,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ****************************************
  // registered write and read
  // ****************************************
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // dmso_stack_mem

// [rtl/dmso_exec.v]
// executor for multiply step, not, or, nop, push, pop and reset sequence
// How it works
// - mult step uses a:b as one 64-bit unsigned pair, result back there.
// - each multiply step does one shift-and-add; repeat N times for N bits.
// - a becomes (a + r when b[0]) shifted right, a[31] forced zero.
// - b[31] takes low bit of that sum, b[30:0] takes b shifted right.
// - multiply step never writes r, multiplicand stays for all steps.
// - nop is one byte and changes no register, flag or memory.
// - pop drops newest entry, restores prior pointer, flags untouched.
// - reset sequence runs five bit ops on 54/55, requests reset, sets s/z.
// - push stores a 6-bit immediate 0..63 on the stack, flags untouched.
// - stacked ram pointer spans two 64-word pages, values 0 to 127.
`timescale 1ns/10ps
`include "dmso_map.vh"
module dmso_exec #(
  parameter STACK_AW = 3
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        instr_valid,
  input  wire [3:0]  instr_op,
  input  wire [1:0]  instr_p1,
  input  wire [1:0]  instr_p2,
  input  wire [5:0]  instr_imm,
  input  wire [6:0]  instr_bit,
  input  wire [31:0] instr_data,
  output reg         busy,
  output reg  [31:0] acc_a,
  output reg  [31:0] acc_b,
  output reg  [31:0] acc_r,
  output reg         flag_c,
  output reg         flag_o,
  output reg         flag_s,
  output reg         flag_z,
  output reg  [6:0]  ram_addr,
  output reg         stack_err,
  output reg         ctl_bit0,
  output reg         ctl_bit1,
  output reg         page_bit,
  output reg         legacy_reset_alias
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SEQ  = 2'h1;
  localparam ST_POP  = 2'h2;

  reg  [1:0]          state;
  reg  [2:0]          step;
  reg  [STACK_AW:0]   depth;
  wire [6:0]          mem_rdata;

  // ****************************************
  // helper functions
  // ****************************************
  function [31:0] acc_pick;
    input [1:0]  sel;
    input [31:0] va;
    input [31:0] vb;
    input [31:0] vr;
    begin
      case (sel)
        `DMSO_SEL_A: acc_pick = va;
        `DMSO_SEL_B: acc_pick = vb;
        default:     acc_pick = vr;
      endcase
    end
  endfunction

  // sequence step table: {set, bit address}
  function [7:0] seq_op;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    seq_op = {1'b0, `DMSO_BIT_CTL0};
        3'h1:    seq_op = {1'b0, `DMSO_BIT_CTL1};
        3'h2:    seq_op = {1'b1, `DMSO_BIT_CTL1};
        3'h3:    seq_op = {1'b1, `DMSO_BIT_CTL0};
        default: seq_op = {1'b0, `DMSO_BIT_CTL1};
      endcase
    end
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire        take     = instr_valid && (state == ST_IDLE);
  wire        sel_ok1  = (instr_p1 != 2'h3);
  wire        sel_ok2  = (instr_p2 != 2'h3);
  wire [31:0] opnd1    = acc_pick(instr_p1, acc_a, acc_b, acc_r);
  wire [31:0] opnd2    = acc_pick(instr_p2, acc_a, acc_b, acc_r);
  wire        do_mult  = take && (instr_op == `DMSO_OP_MULT);
  wire        do_not   = take && (instr_op == `DMSO_OP_NOT) && sel_ok1;
  wire        do_or    = take && (instr_op == `DMSO_OP_OR) && sel_ok1 &&
                         sel_ok2 && (instr_p1 != instr_p2);
  wire        do_load  = take && (instr_op == `DMSO_OP_LOAD) && sel_ok1;
  wire        do_push  = take && (instr_op == `DMSO_OP_PUSH);
  wire        do_pop   = take && (instr_op == `DMSO_OP_POP);
  wire        do_rst   = take && (instr_op == `DMSO_OP_RST);
  wire        do_bit   = take && ((instr_op == `DMSO_OP_BCLR) ||
                                  (instr_op == `DMSO_OP_BITS));
  wire        can_pop  = (depth != {(STACK_AW+1){1'b0}});
  wire        can_push = (depth != {1'b1, {STACK_AW{1'b0}}});

  // ****************************************
  // multiply step and not/or result datapath
  // ****************************************
  wire [31:0] addend   = acc_b[0] ? acc_r : `DMSO_ACC_RST;
  wire [32:0] mul_sum  = {1'b0, acc_a} + {1'b0, addend};
  wire [31:0] mul_a    = {1'b0, mul_sum[31:1]};
  wire [31:0] mul_b    = {mul_sum[0], acc_b[31:1]};
  wire [31:0] logic_v  = do_not ? ~opnd1 : (opnd1 | opnd2);
  wire [1:0]  logic_d  = instr_p1;

  // ****************************************
  // bit operation source: instruction or sequence
  // ****************************************
  wire [7:0]  sq       = seq_op(step);
  wire        bit_en   = do_bit || (state == ST_SEQ);
  wire        bit_set  = (state == ST_SEQ) ? sq[7] :
                         (instr_op == `DMSO_OP_BITS);
  wire [6:0]  bit_adr  = (state == ST_SEQ) ? sq[6:0] : instr_bit;
  wire        next_ctl0 = (bit_en && bit_adr == `DMSO_BIT_CTL0) ?
                          bit_set : ctl_bit0;
  wire        next_ctl1 = (bit_en && bit_adr == `DMSO_BIT_CTL1) ?
                          bit_set : ctl_bit1;

  // ****************************************
  // accumulators and flags
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_a  <= `DMSO_ACC_RST;
      acc_b  <= `DMSO_ACC_RST;
      acc_r  <= `DMSO_ACC_RST;
      flag_c <= 1'b0;
      flag_o <= 1'b0;
      flag_s <= 1'b0;
      flag_z <= 1'b1;
    end else if (do_mult) begin
      // one shift-and-add per instruction, r left alone
      acc_a  <= mul_a;
      acc_b  <= mul_b;
      flag_s <= mul_a[31];
      flag_z <= ({mul_a, mul_b} == 64'h0);
    end else if (do_not || do_or) begin
      if (logic_d == `DMSO_SEL_A) begin
        acc_a <= logic_v;
      end
      if (logic_d == `DMSO_SEL_B) begin
        acc_b <= logic_v;
      end
      if (logic_d == `DMSO_SEL_R) begin
        acc_r <= logic_v;
      end
      flag_c <= 1'b0;
      flag_o <= 1'b0;
      flag_s <= logic_v[31];
      flag_z <= (logic_v == `DMSO_ACC_RST);
    end else if (do_load) begin
      if (instr_p1 == `DMSO_SEL_A) begin
        acc_a <= instr_data;
      end
      if (instr_p1 == `DMSO_SEL_B) begin
        acc_b <= instr_data;
      end
      if (instr_p1 == `DMSO_SEL_R) begin
        acc_r <= instr_data;
      end
    end else if (state == ST_SEQ && step == `DMSO_RST_STEPS - 3'h1) begin
      // last op clears a control bit: result zero, positive
      flag_s <= 1'b0;
      flag_z <= 1'b1;
    end
    // nop falls through: nothing written
  end

  // ****************************************
  // control bits and reset sequence
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      step               <= 3'h0;
      ctl_bit0           <= 1'b0;
      ctl_bit1           <= 1'b0;
      page_bit           <= 1'b0;
      legacy_reset_alias <= 1'b0;
    end else begin
      ctl_bit0 <= next_ctl0;
      ctl_bit1 <= next_ctl1;
      if (bit_en && bit_adr == `DMSO_BIT_PAGE) begin
        page_bit <= bit_set;
      end
      // reset request when ctl0 rises while ctl1 is set
      legacy_reset_alias <= next_ctl0 && !ctl_bit0 && ctl_bit1;
      case (state)
        ST_IDLE: begin
          step <= 3'h0;
          if (do_rst) begin
            state <= ST_SEQ;
          end else if (do_pop && can_pop) begin
            state <= ST_POP;
          end
        end
        ST_SEQ: begin
          if (step == `DMSO_RST_STEPS - 3'h1) begin
            state <= ST_IDLE;
            step  <= 3'h0;
          end else begin
            step <= step + 3'h1;
          end
        end
        ST_POP: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (do_rst || (do_pop && can_pop)) ||
              (state == ST_SEQ && step != `DMSO_RST_STEPS - 3'h1);
    end
  end

  // ****************************************
  // ram address stack
  // ****************************************
  // newest entry lives in ram_addr, older ones in the memory
  wire [STACK_AW-1:0] wr_ptr = depth[STACK_AW-1:0];
  wire [STACK_AW-1:0] rd_ptr = depth[STACK_AW-1:0] - {{(STACK_AW-1){1'b0}},
                                                      1'b1};

  dmso_stack_mem #(
    .AW (STACK_AW),
    .DW (7)
  ) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (do_push && can_push),
    .wr_addr (wr_ptr),
    .wr_data (ram_addr),
    .rd_addr (rd_ptr),
    .rd_data (mem_rdata)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      depth     <= {(STACK_AW+1){1'b0}};
      ram_addr  <= `DMSO_PTR_RST;
      stack_err <= 1'b0;
    end else if (do_push) begin
      if (can_push) begin
        // page bit selects one of two 64-word pages
        ram_addr <= {page_bit, instr_imm};
        depth    <= depth + {{STACK_AW{1'b0}}, 1'b1};
      end else begin
        stack_err <= 1'b1;
      end
    end else if (do_pop) begin
      if (can_pop) begin
        depth <= depth - {{STACK_AW{1'b0}}, 1'b1};
      end else begin
        stack_err <= 1'b1;
      end
    end else if (state == ST_POP) begin
      ram_addr <= mem_rdata;
    end
  end

endmodule // dmso_exec

// [tb/dmso_exec_checker.sv]
// assertion checker for the instruction executor ports
`timescale 1ns/10ps
`include "dmso_map.vh"
module dmso_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic        busy,
  input wire logic [3:0]  instr_op,
  input wire logic [1:0]  instr_p1,
  input wire logic [1:0]  instr_p2,
  input wire logic [5:0]  instr_imm,
  input wire logic [31:0] acc_a,
  input wire logic [31:0] acc_b,
  input wire logic [31:0] acc_r,
  input wire logic        flag_c,
  input wire logic        flag_o,
  input wire logic        flag_s,
  input wire logic        flag_z,
  input wire logic        stack_err,
  input wire logic        page_bit,
  input wire logic        ctl_bit0,
  input wire logic        ctl_bit1,
  input wire logic        legacy_reset_alias,
  input wire logic [6:0]  ram_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // helpers
  // ****************************************
  wire        go  = instr_valid && !busy;
  wire [3:0]  op  = instr_op;
  wire [31:0] sum = acc_a + (acc_b[0] ? acc_r : 32'h0);
  wire [3:0]  fl  = {flag_c, flag_o, flag_s, flag_z};
  // ****************************************
  // properties
  // ****************************************
  mult_pair_a: assert property (go && op == `DMSO_OP_MULT |=>
    {acc_a[30:0], acc_b[31]} == $past(sum)) else $error("mult sum wrong");
  mult_msb_a: assert property (go && op == `DMSO_OP_MULT |=>
    !acc_a[31] && !flag_s && flag_z == ({acc_a, acc_b} == 64'h0))
    else $error("mult msb or flags wrong");
  mult_shift_a: assert property (go && op == `DMSO_OP_MULT |=>
    {1'b0, acc_b[30:0]} == $past(acc_b) >> 1) else $error("mult b shift");
  mult_keep_a: assert property (go && op == `DMSO_OP_MULT |=>
    $stable(acc_r) && $stable(fl[3:2])) else $error("mult touched r");
  nop_hold_a: assert property (go && op == `DMSO_OP_NOP |=>
    $stable(acc_a) && $stable(acc_b) && $stable(acc_r) && $stable(fl)
    && $stable(ram_addr)) else $error("nop changed state");
  pop_step_a: assert property (go && op == `DMSO_OP_POP |=>
    $stable(fl) and (stack_err or (busy ##1 !busy)))
    else $error("pop timing or flags");
  push_top_a: assert property (go && op == `DMSO_OP_PUSH &&
    !stack_err |=> $stable(fl) && (stack_err ||
    ram_addr == {$past(page_bit), $past(instr_imm)}))
    else $error("push top wrong");
  rst_busy_a: assert property (go && op == `DMSO_OP_RST |=>
    busy[*5] ##1 (!busy && !flag_s && flag_z && ctl_bit0 && !ctl_bit1))
    else $error("reset sequence end state");
  rst_pulse_a: assert property (go && op == `DMSO_OP_RST |=>
    !legacy_reset_alias[*4] ##1 legacy_reset_alias ##1 !legacy_reset_alias)
    else $error("reset pulse timing");
  not_flags_a: assert property (go && op == `DMSO_OP_NOT &&
    instr_p1 == `DMSO_SEL_A |=> acc_a == ~$past(acc_a) && !flag_c && !flag_o
    && flag_s == acc_a[31] && flag_z == (acc_a == 32'h0))
    else $error("not result or flags");
  or_value_a: assert property (go && op == `DMSO_OP_OR &&
    instr_p1 == `DMSO_SEL_B && instr_p2 == `DMSO_SEL_R |=>
    acc_b == ($past(acc_b) | $past(acc_r))) else $error("or result");
endmodule // dmso_chk
bind dmso_exec dmso_chk u_chk (.clk_sys, .rst_n, .instr_valid, .busy,
  .instr_op, .instr_p1, .instr_p2, .instr_imm, .acc_a, .acc_b, .acc_r,
  .flag_c, .flag_o, .flag_s, .flag_z, .stack_err, .page_bit, .ctl_bit0,
  .ctl_bit1, .legacy_reset_alias, .ram_addr);

// [tb/tb_top.sv]
// self-checking bench for the instruction executor
`timescale 1ns/10ps
`include "dmso_map.vh"
module tb_top;
  logic        clk_sys = 0, rst_n = 0, instr_valid = 0;
  logic [3:0]  instr_op = 0;
  logic [1:0]  instr_p1 = 0, instr_p2 = 0;
  logic [5:0]  instr_imm = 0;
  logic [6:0]  instr_bit = 0, mtop = 0;
  logic [31:0] instr_data = 0, s, bo;
  wire         busy, flag_c, flag_o, flag_s, flag_z, stack_err;
  wire         ctl_bit0, ctl_bit1, page_bit, legacy_reset_alias;
  wire  [31:0] acc_a, acc_b, acc_r;
  wire  [6:0]  ram_addr;
  int          mismatches = 0, n_tests = 0, i, j;
  logic [31:0] m [3] = '{default: 32'h0};
  logic [3:0]  mf = 4'h1;
  logic        mr = 0, m0 = 0, m1 = 0, mp = 0, me = 0;
  logic [6:0]  q [$];
  logic [63:0] prod;
  always #25 clk_sys = ~clk_sys;
  dmso_exec u_dut (.clk_sys, .rst_n, .instr_valid, .instr_op, .instr_p1,
    .instr_p2, .instr_imm, .instr_bit, .instr_data, .busy, .acc_a, .acc_b,
    .acc_r, .flag_c, .flag_o, .flag_s, .flag_z, .ram_addr, .stack_err,
    .ctl_bit0, .ctl_bit1, .page_bit, .legacy_reset_alias);
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // drives one instruction, updates the model, compares every output
  task automatic go(input logic [3:0] op, input logic [1:0] p1 = 0,
    input logic [1:0] p2 = 0, input logic [5:0] imm = 0,
    input logic [6:0] b = 0, input logic [31:0] d = 0);
    @(negedge clk_sys);
    {instr_valid, instr_op, instr_p1, instr_p2} = {1'b1, op, p1, p2};
    {instr_imm, instr_bit, instr_data} = {imm, b, d};
    @(negedge clk_sys);
    instr_valid = 0;
    for (int k = 0; k < 8 && busy === 1'b1; k++) @(negedge clk_sys);
    mr = 0;
    case (op)
      `DMSO_OP_MULT: begin
        s = m[0] + (m[1][0] ? m[2] : 32'h0);
        m[0] = {1'b0, s[31:1]};
        m[1] = {s[0], m[1][31:1]};
        mf[1:0] = {1'b0, {m[0], m[1]} == 64'h0};
      end
      `DMSO_OP_NOT, `DMSO_OP_OR: if (p1 < 3 && (op == `DMSO_OP_NOT ||
        (p2 < 3 && p2 != p1))) begin
        m[p1] = op == `DMSO_OP_NOT ? ~m[p1] : m[p1] | m[p2];
        mf = {2'h0, m[p1][31], m[p1] == 32'h0};
      end
      `DMSO_OP_LOAD: if (p1 < 3) begin
        m[p1] = d;
      end
      `DMSO_OP_PUSH: if (q.size() == 8) me = 1;
        else begin
          q.push_back(mtop);
          mtop = {mp, imm};
        end
      `DMSO_OP_POP: if (q.size() == 0) me = 1;
        else mtop = q.pop_back();
      `DMSO_OP_RST: begin
        {m0, m1} = 2'h2;
        mf[1:0] = 2'h1;
      end
      `DMSO_OP_BCLR, `DMSO_OP_BITS: begin
        // request pulse when 54 rises while 55 is set
        mr = op == `DMSO_OP_BITS && b == `DMSO_BIT_CTL0 && !m0 && m1;
        if (b == `DMSO_BIT_CTL0) m0 = op == `DMSO_OP_BITS;
        if (b == `DMSO_BIT_CTL1) m1 = op == `DMSO_OP_BITS;
        if (b == `DMSO_BIT_PAGE) mp = op == `DMSO_OP_BITS;
      end
      default: ;
    endcase
    cmp(acc_a, m[0]);
    cmp(acc_b, m[1]);
    cmp(acc_r, m[2]);
    cmp({flag_c, flag_o, flag_s, flag_z}, mf);
    cmp(ram_addr, mtop);
    cmp({legacy_reset_alias, busy, stack_err, page_bit, ctl_bit1, ctl_bit0},
      {mr, 1'b0, me, mp, m1, m0});
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hac27b0fd));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1;
    for (i = 0; i < 3; i++) go(`DMSO_OP_LOAD, i[1:0], , , , $urandom);
    go(`DMSO_OP_NOP);
    go(4'hf);
    $display("test nop done");
    for (i = 0; i < 16; i++) begin
      go(`DMSO_OP_NOT, i[1:0], i[3:2]);
      go(`DMSO_OP_OR, i[3:2], i[1:0]);
    end
    $display("test bitwise done");
    for (j = 0; j < 2; j++) begin
      bo = $urandom;
      go(`DMSO_OP_LOAD, `DMSO_SEL_A);
      go(`DMSO_OP_LOAD, `DMSO_SEL_B, , , , bo);
      go(`DMSO_OP_LOAD, `DMSO_SEL_R, , , , $urandom & 32'h7fff_ffff);
      repeat (j ? 8 : 32) go(`DMSO_OP_MULT);
      prod = j ? (({56'h0, bo[7:0]} * {32'h0, m[2]}) << 24) | (bo >> 8)
        : {32'h0, bo} * {32'h0, m[2]};
      cmp(acc_a, prod[63:32]);
      cmp(acc_b, prod[31:0]);
    end
    $display("test mult done");
    go(`DMSO_OP_BITS, , , , `DMSO_BIT_PAGE);
    for (i = 0; i < 26; i++) begin
      if (i == 4) go(`DMSO_OP_BCLR, , , , `DMSO_BIT_PAGE);
      go(i < 8 || i > 16 ? `DMSO_OP_PUSH : `DMSO_OP_POP, , ,
        6'($urandom));
    end
    $display("test stack done");
    go(`DMSO_OP_BITS, , , , `DMSO_BIT_CTL1);
    go(`DMSO_OP_RST);
    go(`DMSO_OP_BCLR, , , , `DMSO_BIT_CTL0);
    go(`DMSO_OP_BITS, , , , `DMSO_BIT_CTL1);
    go(`DMSO_OP_BITS, , , , `DMSO_BIT_CTL0);
    go(`DMSO_OP_MULT);
    $display("test sequence done");
    tally_and_finish;
  end
endmodule // tb_top
